//--- verilog/port0_pins_regs.svh
/*
 * Register offsets, field positions, strap codes and clock rates of the
 * port 0 clock/collision pin block.
 * Assumes it is included by bare name wherever these values are needed.
 */
`ifndef PORT0_PINS_REGS_SVH
`define PORT0_PINS_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------
`define BASIC_CTRL_ADDR   4'h0
`define SPECIAL_CTRL_ADDR 4'h1
`define PORT_STATUS_ADDR  4'h2

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define ISOLATE_BIT       10
`define CLK_DIR_BIT       0
`define CLK_STRENGTH_BIT  1
`define STAT_MODE_LSB     0
`define STAT_COL_BIT      4
`define STAT_READY_BIT    5
`define ISOLATE_RESET     1'b0

// ----------------------------------------------------------------------
// Mode strap codes.
// ----------------------------------------------------------------------
`define STRAP_MII_MAC     3'h0
`define STRAP_MII_PHY     3'h1
`define STRAP_TURBO_12    3'h2
`define STRAP_TURBO_16    3'h3
`define STRAP_RMII_OUT_12 3'h4
`define STRAP_RMII_OUT_16 3'h5
`define STRAP_RMII_IN     3'h6

// ----------------------------------------------------------------------
// Clock rates in MHz.
// ----------------------------------------------------------------------
`define SYS_CLK_MHZ       125
`define MII_CLK_MHZ       25
`define TURBO_CLK_MHZ     50
`define RMII_CLK_MHZ      50

`endif

//--- verilog/port0_pins_pkg.sv
/*
 * Types shared by the port 0 pin block and its link-side stage.
 * Assumes the register header supplies all numeric constants.
 */
package port0_pins_pkg;

    // Decoded port mode.
    typedef enum logic [2:0] {
        MODE_MII_MAC,
        MODE_MII_PHY,
        MODE_TURBO,
        MODE_RMII_OUT,
        MODE_RMII_IN,
        MODE_RESERVED
    } mode_t;

    // Link-side state.
    typedef struct packed {
        logic       rst_s1;
        logic       rst_s2;
        logic       req_s1;
        logic       req_s2;
        logic       seen;
        logic [3:0] data;
        logic       valid;
    } link_state_t;

    // System-side state.
    typedef struct packed {
        logic [2:0]  strap_s1;
        logic [2:0]  strap_s2;
        logic [2:0]  mode_strap;
        logic        isolate;
        logic        clk_dir;
        logic        clk_strength;
        logic        col_s1;
        logic        col_s2;
        logic        col_seen;
        logic        col_out;
        logic        ack_s1;
        logic        ack_s2;
        logic        req_tgl;
        logic [3:0]  word;
        logic        word_valid;
        logic [2:0]  div_cnt;
        logic        ref_clk;
        logic [15:0] rdata;
    } top_state_t;

endpackage

//--- verilog/port0_link_if.sv
/*
 * Carrier for the transmit word handshake between the system clock side
 * and the link clock side of the port 0 pin block.
 * Assumes the sys side holds data stable while a request is open.
 */
`timescale 1ns/1ps
interface port0_link_if;
    logic [3:0] data;
    logic       valid;
    logic       req_tgl;
    logic       ack_tgl;

    modport sys  (output data, output valid, output req_tgl, input ack_tgl);
    modport link (input data, input valid, input req_tgl, output ack_tgl);
endinterface

//--- verilog/port0_link_stage.sv
/*
 * Link clock stage: takes handed-over transmit words and drives the port
 * data and valid pins from flip-flops on the port reference clock.
 * Assumes link_clk is the resolved level of the reference clock pin.
 */
`timescale 1ns/1ps
module port0_link_stage
    import port0_pins_pkg::*;
(
    input  wire logic       link_clk,
    input  wire logic       rst_b,
    port0_link_if.link      lnk,
    output logic [3:0]      port0_out_data,
    output logic            port0_out_valid
);
    import port0_pins_pkg::*;

    link_state_t s_r;
    link_state_t s_nxt;

    // --------------------------------------------------------------------
    // Handshake receive.
    // --------------------------------------------------------------------
    // A new toggle means a stable word waits; it is launched on this
    // clock so the pins change only relative to the reference clock.
    always_comb begin
        s_nxt        = s_r;
        s_nxt.rst_s1 = rst_b;
        s_nxt.rst_s2 = s_r.rst_s1;
        s_nxt.req_s1 = lnk.req_tgl;
        s_nxt.req_s2 = s_r.req_s1;
        if (!s_r.rst_s2) begin
            s_nxt.seen  = 1'b0; // Known start for the toggle pair.
            s_nxt.data  = 4'h0;
            s_nxt.valid = 1'b0;
        end else if (s_r.req_s2 != s_r.seen) begin
            s_nxt.seen  = s_r.req_s2;
            s_nxt.data  = lnk.data;
            s_nxt.valid = lnk.valid;
        end
    end

    always_ff @(posedge link_clk) begin
        s_r <= s_nxt;
    end

    assign lnk.ack_tgl      = s_r.seen;
    assign port0_out_data  = s_r.data;
    assign port0_out_valid = s_r.valid;
endmodule

//--- verilog/port0_pin_mux.sv
/*
 * Port 0 reference clock and collision pin control: mode strap capture,
 * pin directions, isolate gating, clock divider and a small register file.
 * Assumes link_clk carries the resolved reference clock pin level, and a
 * single-cycle register bus master on sys_clk.
 */
// Summary of operation
// - MAC mode: clock pin input times outputs.
// - MII PHY mode: clock pin output times outputs.
// - Isolate disables clock and collision drivers.
// - Strength bit picks 12 or 16 mA in turbo and RMII modes.
// - RMII clock 50 MHz nominal, 62.5 MHz when driven, times 2-bit data.
// - RMII direction bit: clear input, set output.
// - Input has pull-down; output disables buffer, pull-down.
// - Isolated RMII input disables buffer and pull-down.
// - MII PHY mode drives collision toward MAC.
// - RMII mode leaves collision pin unused.
// - Decode three-bit strap into port modes.
// - Straps captured when reset is released.
`timescale 1ns/1ps
`include "port0_pins_regs.svh"
module port0_pin_mux (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_b,
    input  wire logic                     link_clk,
    input  wire logic [2:0]               port0_mode_strap,
    input  wire logic [3:0]               reg_addr,
    input  wire logic [15:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [15:0]                   reg_rdata,
    input  wire logic [3:0]               tx_data,
    input  wire logic                     tx_valid,
    input  wire logic                     tx_load,
    output logic                          tx_ready,
    input  wire logic                     col_req,
    output logic                          col_detect,
    output port0_pins_pkg::mode_t         port_mode,
    input  wire logic                     port0_ref_clock_pin_i,
    output logic                          port0_ref_clock_pin_o,
    output logic                          port0_ref_clock_pin_oe,
    output logic                          port0_ref_clock_pin_ie,
    output logic                          port0_ref_clock_pin_pd,
    output logic                          port0_ref_clock_16ma,
    input  wire logic                     port0_collision_pin_i,
    output logic                          port0_collision_pin_o,
    output logic                          port0_collision_pin_oe,
    output logic [3:0]                    port0_out_data,
    output logic [3:0]                    port0_out_data_oe,
    output logic                          port0_out_valid,
    output logic                          port0_out_valid_oe
);
    import port0_pins_pkg::*;

    // --------------------------------------------------------------------
    // Clock divider counts.
    // --------------------------------------------------------------------
    // Half periods round down, so the driven clock is never slower than
    // nominal; 125 MHz cannot give 25 or 50 MHz exactly.
    localparam int MII_HALF   = `SYS_CLK_MHZ / (2 * `MII_CLK_MHZ);
    localparam int TURBO_HALF = `SYS_CLK_MHZ / (2 * `TURBO_CLK_MHZ);
    localparam int RMII_HALF  = `SYS_CLK_MHZ / (2 * `RMII_CLK_MHZ);

    localparam logic [2:0] MII_LAST   = 3'(MII_HALF - 1);
    localparam logic [2:0] TURBO_LAST = 3'(TURBO_HALF - 1);
    localparam logic [2:0] RMII_LAST  = 3'(RMII_HALF - 1);

    top_state_t s_r;
    top_state_t s_nxt;
    mode_t      mode;
    logic       phy_mode;
    logic       rmii_mode;
    logic       mii_phy_side;
    logic       ref_out;
    logic       ref_in_on;
    logic [2:0] div_last;
    logic       ack;

    port0_link_if lnk ();

    // --------------------------------------------------------------------
    // Strap decode.
    // --------------------------------------------------------------------
    // The reserved code turns every driver off rather than guess a mode.
    function automatic mode_t decode_strap(input logic [2:0] code);
        mode_t m;
        m = MODE_RESERVED;
        unique case (code)
            `STRAP_MII_MAC:     m = MODE_MII_MAC;
            `STRAP_MII_PHY:     m = MODE_MII_PHY;
            `STRAP_TURBO_12:    m = MODE_TURBO;
            `STRAP_TURBO_16:    m = MODE_TURBO;
            `STRAP_RMII_OUT_12: m = MODE_RMII_OUT;
            `STRAP_RMII_OUT_16: m = MODE_RMII_OUT;
            `STRAP_RMII_IN:     m = MODE_RMII_IN;
            default:            m = MODE_RESERVED;
        endcase
        return m;
    endfunction

    // Mode classes used by the pin steering below.
    always_comb begin
        mode         = decode_strap(s_r.mode_strap);
        rmii_mode    = (mode == MODE_RMII_OUT) || (mode == MODE_RMII_IN);
        mii_phy_side = (mode == MODE_MII_PHY) || (mode == MODE_TURBO);
        phy_mode     = mii_phy_side || rmii_mode;
        ref_out      = mii_phy_side || (rmii_mode && s_r.clk_dir);
        ref_in_on    = (mode == MODE_MII_MAC)
                    || (rmii_mode && !s_r.clk_dir && !s_r.isolate);
        unique case (mode)
            MODE_MII_PHY: div_last = MII_LAST;
            MODE_TURBO:   div_last = TURBO_LAST;
            default:      div_last = RMII_LAST;
        endcase
    end

    assign ack = s_r.ack_s2;

    // --------------------------------------------------------------------
    // Next-state logic.
    // --------------------------------------------------------------------
    always_comb begin
        s_nxt          = s_r;
        s_nxt.strap_s1 = port0_mode_strap;
        s_nxt.strap_s2 = s_r.strap_s1;
        s_nxt.col_s1   = port0_collision_pin_i;
        s_nxt.col_s2   = s_r.col_s1;
        s_nxt.ack_s1   = lnk.ack_tgl;
        s_nxt.ack_s2   = s_r.ack_s1;
        s_nxt.rdata    = 16'h0000;

        if (!rst_b) begin
            // Straps track the pins all through reset, so the value held
            // at the release is the one kept.
            s_nxt.mode_strap   = s_r.strap_s2;
            s_nxt.isolate      = `ISOLATE_RESET;
            s_nxt.clk_dir      = (s_r.strap_s2 != `STRAP_RMII_IN);
            s_nxt.clk_strength = s_r.strap_s2[0];
            s_nxt.col_seen     = 1'b0;
            s_nxt.col_out      = 1'b0;
            s_nxt.req_tgl      = 1'b0;
            s_nxt.word         = 4'h0;
            s_nxt.word_valid   = 1'b0;
            s_nxt.div_cnt      = 3'h0;
            s_nxt.ref_clk      = 1'b0;
        end else begin
            // Reference clock divider; stands still as an input.
            if (ref_out) begin
                if (s_r.div_cnt >= div_last) begin
                    s_nxt.div_cnt = 3'h0;
                    s_nxt.ref_clk = !s_r.ref_clk;
                end else begin
                    s_nxt.div_cnt = s_r.div_cnt + 3'h1;
                end
            end else begin
                s_nxt.div_cnt = 3'h0;
                s_nxt.ref_clk = 1'b0;
            end

            // Collision to the MAC is only meaningful on the MII side.
            s_nxt.col_out = mii_phy_side && col_req;

            // Transmit word hand-over; a load while busy is dropped.
            if (tx_load && tx_ready) begin
                s_nxt.word       = rmii_mode ? {2'b00, tx_data[1:0]}
                                             : tx_data;
                s_nxt.word_valid = tx_valid;
                s_nxt.req_tgl    = !s_r.req_tgl;
            end

            // Register writes.
            if (reg_wr) begin
                unique case (reg_addr)
                    `BASIC_CTRL_ADDR: begin
                        s_nxt.isolate = reg_wdata[`ISOLATE_BIT];
                    end
                    `SPECIAL_CTRL_ADDR: begin
                        s_nxt.clk_dir      = reg_wdata[`CLK_DIR_BIT];
                        s_nxt.clk_strength = reg_wdata[`CLK_STRENGTH_BIT];
                    end
                    default: begin
                    end
                endcase
            end

            // Register reads; the status read clears the collision flag,
            // but a collision in the same cycle still sets it.
            if (reg_rd) begin
                unique case (reg_addr)
                    `BASIC_CTRL_ADDR: begin
                        s_nxt.rdata[`ISOLATE_BIT] = s_r.isolate;
                    end
                    `SPECIAL_CTRL_ADDR: begin
                        s_nxt.rdata[`CLK_DIR_BIT]      = s_r.clk_dir;
                        s_nxt.rdata[`CLK_STRENGTH_BIT] = s_r.clk_strength;
                    end
                    `PORT_STATUS_ADDR: begin
                        s_nxt.rdata[`STAT_MODE_LSB +: 3] = s_r.mode_strap;
                        s_nxt.rdata[`STAT_COL_BIT]       = s_r.col_seen;
                        s_nxt.rdata[`STAT_READY_BIT]     =
                            (s_r.req_tgl == ack);
                        s_nxt.col_seen = 1'b0;
                    end
                    default: begin
                    end
                endcase
            end
            if ((mode == MODE_MII_MAC) && s_r.col_s2) begin
                s_nxt.col_seen = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        s_r <= s_nxt;
    end

    // --------------------------------------------------------------------
    // Link side hand-over.
    // --------------------------------------------------------------------
    assign lnk.data    = s_r.word;
    assign lnk.valid   = s_r.word_valid;
    assign lnk.req_tgl = s_r.req_tgl;

    port0_link_stage u_link (
        .link_clk        (link_clk),
        .rst_b           (rst_b),
        .lnk             (lnk.link),
        .port0_out_data  (port0_out_data),
        .port0_out_valid (port0_out_valid)
    );

    // --------------------------------------------------------------------
    // Pin steering.
    // --------------------------------------------------------------------
    // Isolate only gates drivers on the PHY side; in MAC mode the pins
    // face an external PHY and stay live.
    always_comb begin
        port0_ref_clock_pin_o  = s_r.ref_clk;
        port0_ref_clock_pin_oe = ref_out && !s_r.isolate;
        port0_ref_clock_pin_ie = ref_in_on;
        port0_ref_clock_pin_pd = ref_in_on;
        port0_ref_clock_16ma   = s_r.clk_strength
                              && ((mode == MODE_TURBO) || rmii_mode);
        port0_collision_pin_o  = s_r.col_out;
        port0_collision_pin_oe = mii_phy_side && !s_r.isolate;
        if (mode == MODE_MII_MAC) begin
            port0_out_data_oe  = 4'hF;
            port0_out_valid_oe = 1'b1;
        end else if (mii_phy_side) begin
            port0_out_data_oe  = s_r.isolate ? 4'h0 : 4'hF;
            port0_out_valid_oe = !s_r.isolate;
        end else if (rmii_mode) begin
            port0_out_data_oe  = s_r.isolate ? 4'h0 : 4'h3;
            port0_out_valid_oe = !s_r.isolate;
        end else begin
            port0_out_data_oe  = 4'h0;
            port0_out_valid_oe = 1'b0;
        end
    end

    // Transmit is refused in the reserved mode and while a hand-over is open.
    assign col_detect = (mode == MODE_MII_MAC) && s_r.col_s2;
    assign tx_ready   = (s_r.req_tgl == ack)
                     && (phy_mode || (mode == MODE_MII_MAC));
    assign reg_rdata  = s_r.rdata;
    assign port_mode  = mode;
endmodule

//--- testbench/port0_pin_mux_props.sv
/* Concurrent checks on the port 0 pin block, seen from its top ports.
   Assumes a single-cycle register master on sys_clk. */
`timescale 1ns/1ps
`include "port0_pins_regs.svh"
module port0_pin_mux_props (
    input wire logic                  sys_clk,
    input wire logic                  rst_b,
    input wire logic [3:0]            reg_addr,
    input wire logic [15:0]           reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [15:0]           reg_rdata,
    input wire logic                  col_req,
    input wire logic                  col_detect,
    input wire port0_pins_pkg::mode_t port_mode,
    input wire logic                  port0_ref_clock_pin_oe,
    input wire logic                  port0_ref_clock_pin_ie,
    input wire logic                  port0_ref_clock_pin_pd,
    input wire logic                  port0_ref_clock_16ma,
    input wire logic                  port0_collision_pin_i,
    input wire logic                  port0_collision_pin_o,
    input wire logic                  port0_collision_pin_oe,
    input wire logic [3:0]            port0_out_data,
    input wire logic                  port0_out_valid_oe
);
    import port0_pins_pkg::*;
    logic iso_r;
    logic rmii;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------------
    // Isolate shadow: no port shows the bit, so bus writes are tracked.
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            iso_r <= `ISOLATE_RESET;
        end else if (reg_wr && reg_addr == `BASIC_CTRL_ADDR) begin
            iso_r <= reg_wdata[`ISOLATE_BIT];
        end
    end
    assign rmii = port_mode inside {MODE_RMII_OUT, MODE_RMII_IN};
    a_mac_clk_in: assert property (port_mode == MODE_MII_MAC |->
        !port0_ref_clock_pin_oe && port0_ref_clock_pin_ie)
        else $error("clock pin not an input in MAC mode");
    a_phy_clk_out: assert property (
        port_mode inside {MODE_MII_PHY, MODE_TURBO} && !iso_r
        |-> port0_ref_clock_pin_oe) else $error("clock pin not driven");
    a_iso_gates: assert property (iso_r && port_mode != MODE_MII_MAC
        |-> !port0_ref_clock_pin_oe && !port0_collision_pin_oe
        && !port0_out_valid_oe) else $error("isolate left a driver on");
    a_strength_pick: assert property (reg_wr &&
        reg_addr == `SPECIAL_CTRL_ADDR
        && port_mode inside {MODE_TURBO, MODE_RMII_OUT}
        |=> port0_ref_clock_16ma == $past(reg_wdata[`CLK_STRENGTH_BIT]))
        else $error("clock strength does not follow its bit");
    a_rmii_two_bit: assert property (rmii |->
        port0_out_data[3:2] == 2'h0) else $error("upper data bits in RMII");
    a_rmii_dir: assert property (reg_wr &&
        reg_addr == `SPECIAL_CTRL_ADDR && rmii && !iso_r
        |=> port0_ref_clock_pin_oe == $past(reg_wdata[`CLK_DIR_BIT]))
        else $error("clock direction does not follow its bit");
    a_rmii_buffers: assert property (rmii && !iso_r |->
        port0_ref_clock_pin_ie == !port0_ref_clock_pin_oe
        && port0_ref_clock_pin_pd == !port0_ref_clock_pin_oe)
        else $error("clock pin buffer or pull-down wrong");
    a_iso_in_off: assert property (iso_r && rmii |->
        !port0_ref_clock_pin_ie && !port0_ref_clock_pin_pd)
        else $error("isolated clock input still enabled");
    a_col_sense: assert property (port_mode == MODE_MII_MAC &&
        port0_collision_pin_i [*4] |-> col_detect)
        else $error("collision input not seen");
    a_col_drive: assert property (
        port_mode inside {MODE_MII_PHY, MODE_TURBO} && !iso_r
        |-> port0_collision_pin_oe && port0_collision_pin_o == $past(col_req))
        else $error("collision output does not follow request");
    a_col_unused: assert property (rmii |-> !port0_collision_pin_oe)
        else $error("collision pin driven in RMII mode");
    a_read_once: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
        else $error("read data present without a read");
endmodule
bind port0_pin_mux port0_pin_mux_props port0_pin_mux_props_inst (
    .sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .col_req, .col_detect, .port_mode, .port0_ref_clock_pin_oe,
    .port0_ref_clock_pin_ie, .port0_ref_clock_pin_pd, .port0_ref_clock_16ma,
    .port0_collision_pin_i, .port0_collision_pin_o, .port0_collision_pin_oe,
    .port0_out_data, .port0_out_valid_oe);

//--- testbench/port0_far_end.sv
/* Model of the external PHY or MAC facing port 0.
   Assumes the bench resolves pin levels from the enables given here. */
`timescale 1ns/1ps
module port0_far_end (
    input  wire logic clk_en,
    input  wire logic col_en,
    input  wire logic col_event,
    output logic      clk_drv,
    output logic      clk_oe,
    output logic      col_drv,
    output logic      col_oe
);
    // A free-running clock, offset 5 ns so its edges never meet a sys_clk edge.
    initial begin
        clk_drv = 1'b0;
        #5;
        forever #32 clk_drv = ~clk_drv;
    end
    // The far PHY drives the collision pin only in MAC mode.
    assign col_oe  = col_en;
    assign col_drv = col_event;
    assign clk_oe  = clk_en;
endmodule

//--- testbench/tb_port0_pin_mux.sv
/* Self-checking bench for the port 0 pin block.
   Assumes the bound checker and the far-end model beside it. */
`timescale 1ns/1ps
`include "port0_pins_regs.svh"
module tb_port0_pin_mux;
    import port0_pins_pkg::*;
    logic        sys_clk, rst_b, reg_wr, reg_rd, tx_valid, tx_load, col_req;
    logic        col_ev, clk_en, col_en, clk_drv, clk_oe, col_drv, col_oe;
    logic        tx_ready, col_detect, link_clk, col_wire;
    logic [2:0]  strap;
    logic [3:0]  reg_addr, tx_data, port0_out_data, port0_out_data_oe;
    logic [15:0] reg_wdata, reg_rdata, rdata;
    logic        port0_ref_clock_pin_o, port0_ref_clock_pin_oe;
    logic        port0_ref_clock_pin_ie, port0_ref_clock_pin_pd;
    logic        port0_ref_clock_16ma, port0_collision_pin_o;
    logic        port0_collision_pin_oe, port0_out_valid, port0_out_valid_oe;
    mode_t       port_mode;
    int          err_total, num_checks;
    mode_t       exp_mode [8] = '{MODE_MII_MAC, MODE_MII_PHY, MODE_TURBO,
        MODE_TURBO, MODE_RMII_OUT, MODE_RMII_OUT, MODE_RMII_IN, MODE_RESERVED};
    // Pin enables per strap: {oe, ie, pd, 16ma, collision oe}.
    logic [4:0]  exp_pins [8] = '{5'h0C, 5'h11, 5'h11, 5'h13, 5'h10, 5'h12,
        5'h0C, 5'h00};
    // Pull-down on the clock pin, pull-up on the collision pin.
    assign link_clk = port0_ref_clock_pin_oe ? port0_ref_clock_pin_o :
                      (clk_oe ? clk_drv : 1'b0);
    assign col_wire = port0_collision_pin_oe ? port0_collision_pin_o :
                      (col_oe ? col_drv : 1'b1);
    port0_pin_mux port0_pin_mux_inst (.sys_clk, .rst_b, .link_clk,
        .port0_mode_strap(strap), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .tx_data, .tx_valid, .tx_load, .tx_ready, .col_req,
        .col_detect, .port_mode, .port0_ref_clock_pin_i(link_clk),
        .port0_ref_clock_pin_o, .port0_ref_clock_pin_oe,
        .port0_ref_clock_pin_ie, .port0_ref_clock_pin_pd,
        .port0_ref_clock_16ma, .port0_collision_pin_i(col_wire),
        .port0_collision_pin_o, .port0_collision_pin_oe, .port0_out_data,
        .port0_out_data_oe, .port0_out_valid, .port0_out_valid_oe);
    port0_far_end port0_far_end_inst (.clk_en, .col_en, .col_event(col_ev),
        .clk_drv, .clk_oe, .col_drv, .col_oe);
    // ------------------------------------------------------------------
    // Bus, hand-over and verdict tasks.
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rdata = reg_rdata;
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 400; i++) begin
            @(posedge sys_clk);
            if (tx_ready === 1'b1) break;
        end
    endtask
    // The word is only checked once the acknowledge has come home.
    task automatic send(input logic [3:0] d);
        wait_ready();
        tx_load <= 1'b1;
        tx_data <= d;
        tx_valid <= 1'b1;
        @(posedge sys_clk);
        tx_load <= 1'b0;
        @(posedge sys_clk);
        wait_ready();
        chk({15'h0, tx_ready}, 16'h1);
        repeat (16) @(posedge sys_clk);
        #1;
    endtask
    // Straps are held through reset; the far end follows the mode.
    task automatic do_reset(input logic [2:0] s, input int n);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        strap <= s;
        col_req <= 1'b0;
        col_ev <= 1'b0;
        clk_en <= (s == 3'h0 || s == 3'h6);
        col_en <= (s == 3'h0);
        repeat (n) @(posedge sys_clk);
        rst_b <= 1'b1;
    endtask
    task automatic close_out();
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Watchdog well beyond the several hundred cycles the tests need.
    initial begin
        #400000;
        err_total++;
        close_out();
    end
    initial begin
        {rst_b, reg_wr, reg_rd, tx_valid, tx_load, col_req, col_ev} = '0;
        {clk_en, col_en, strap, reg_addr, tx_data, reg_wdata} = '0;
        do_reset(3'h0, 16);
        for (int s = 0; s < 8; s++) begin
            do_reset(s[2:0], 40);
            @(posedge sys_clk);
            strap <= ~s[2:0];
            repeat (8) @(posedge sys_clk);
            #1;
            chk({13'h0, port_mode}, {13'h0, exp_mode[s]});
            chk({11'h0, port0_ref_clock_pin_oe, port0_ref_clock_pin_ie,
                port0_ref_clock_pin_pd, port0_ref_clock_16ma,
                port0_collision_pin_oe}, {11'h0, exp_pins[s]});
            rd(`PORT_STATUS_ADDR);
            chk({13'h0, rdata[2:0]}, s[15:0]);
        end
        do_reset(3'h0, 40);
        send(4'hA);
        chk({7'h0, port0_out_data_oe, port0_out_valid, port0_out_data},
            {7'h0, 4'hF, 1'b1, 4'hA});
        col_ev <= 1'b1;
        repeat (6) @(posedge sys_clk);
        col_ev <= 1'b0;
        #1;
        chk({15'h0, col_detect}, 16'h1);
        repeat (6) @(posedge sys_clk);
        rd(`PORT_STATUS_ADDR);
        chk({15'h0, rdata[`STAT_COL_BIT]}, 16'h1);
        rd(`PORT_STATUS_ADDR);
        chk({15'h0, rdata[`STAT_COL_BIT]}, 16'h0);
        do_reset(3'h1, 40);
        col_req <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        chk({14'h0, port0_collision_pin_oe, col_wire}, 16'h3);
        wr(`BASIC_CTRL_ADDR, 16'h0400);
        chk({13'h0, port0_ref_clock_pin_oe, port0_collision_pin_oe,
            port0_out_valid_oe}, 16'h0);
        wr(`BASIC_CTRL_ADDR, 16'h0000);
        chk({15'h0, port0_ref_clock_pin_oe}, 16'h1);
        send(4'h5);
        chk({11'h0, port0_out_valid, port0_out_data}, 16'h15);
        do_reset(3'h6, 40);
        send(4'hF);
        chk({11'h0, port0_out_valid, port0_out_data}, 16'h13);
        wr(`BASIC_CTRL_ADDR, 16'h0400);
        chk({14'h0, port0_ref_clock_pin_ie, port0_ref_clock_pin_pd},
            16'h0);
        wr(`BASIC_CTRL_ADDR, 16'h0000);
        wr(`SPECIAL_CTRL_ADDR, 16'h0001);
        chk({13'h0, port0_ref_clock_pin_oe, port0_ref_clock_pin_ie,
            port0_ref_clock_pin_pd}, 16'h4);
        wr(`SPECIAL_CTRL_ADDR, 16'h0000);
        chk({13'h0, port0_ref_clock_pin_oe, port0_ref_clock_pin_ie,
            port0_ref_clock_pin_pd}, 16'h3);
        do_reset(3'h5, 40);
        wr(`SPECIAL_CTRL_ADDR, 16'h0001);
        chk({15'h0, port0_ref_clock_16ma}, 16'h0);
        wr(`SPECIAL_CTRL_ADDR, 16'h0003);
        chk({15'h0, port0_ref_clock_16ma}, 16'h1);
        wr(4'hF, 16'hFFFF);
        rd(4'hF);
        chk(rdata, 16'h0);
        close_out();
    end
endmodule
